// ---- dsp_data_space_pkg.sv ----
// Purpose: Shared types and constants of the data space access unit.
// Assumes: 16-bit words, 64K-word data and program spaces.
// Notes: Boundary codes compare against address bits 15..10.
//
// Contract
// RL1: Lower region spans zero to lower boundary minus one
// RL2: Upper region spans top down to upper boundary
// RL3: Middle region between boundaries, may be empty
// RL4: Boundaries move only in 1K-word steps
// RL5: Integrator keeps upper above lower, upper nonempty
// RL6: Boundaries come from two six-bit input buses
// RL7: Lower/upper writes go through one-entry buffer
// RL8: Lower/upper reads beat a waiting buffered write
// RL9: Buffer writes memory in first idle cycle
// RL10: New write flushes buffer and reloads it
// RL11: Flow change leaves no stale buffered write
// RL12: Read after write to same address forwards
// RL13: Middle region accesses bypass the buffer
// RL14: Short direct address is page byte, opcode byte
// RL15: Long direct uses second word, two cycles
// RL16: Indirect uses pointers; dual reads lower and upper
// RL17: Short index is base plus -64..+63
// RL18: Long index is base plus 16-bit signed
// RL19: Stack accesses use the stack pointer
// RL20: Program address from pointer or accumulator
// RL21: Relative branch target within pc-63..pc+64
// RL22: Page field is status_reg_one bits 7..0
// RL23: Region chosen by address bits 15..10 compare
package dsp_data_space_pkg;
	localparam int ADDR_W  = 16;           // Address width
	localparam int DATA_W  = 16;           // Data word width
	localparam int BOUND_W = 6;            // Boundary code width
	localparam int REG_LSB = 10;           // 1K granule position
	localparam int PAGE_W  = 8;            // Page field width
	localparam int SYNC_N  = 3;            // Pin synchroniser depth
	localparam logic [15:0] ST1_RST     = 16'h0000; // status_reg_one reset
	localparam logic [15:0] ST1_WR_MASK = 16'hfcff; // Bits 9..8 reserved
	localparam logic [5:0] LOWER_RST   = 6'h00;    // Boundary before sync
	localparam logic [5:0] UPPER_RST   = 6'h3f;    // Boundary before sync
	localparam logic [15:0] REL_BIAS    = 16'h0001; // pc-relative skew

	// Data addressing modes
	typedef enum logic [6:0] {
		M_SHORT_DIRECT = 7'h01,
		M_LONG_DIRECT  = 7'h02,
		M_INDIRECT     = 7'h04,
		M_DUAL         = 7'h08,
		M_SHORT_INDEX  = 7'h10,
		M_LONG_INDEX   = 7'h20,
		M_STACK        = 7'h40
	} dmode_t;

	// Program addressing modes
	typedef enum logic [2:0] {
		P_POINTER = 3'h1,
		P_ACCUM   = 3'h2,
		P_REL     = 3'h4
	} pmode_t;

	// Data regions
	typedef enum logic [2:0] {
		R_LOWER  = 3'h1,
		R_MIDDLE = 3'h2,
		R_UPPER  = 3'h4
	} region_t;

	// One data access request from the core
	typedef struct packed {
		logic        valid;
		logic        write;
		dmode_t      mode;
		logic [7:0]  short_addr;
		logic [15:0] long_word;
		logic [15:0] ptr_a;
		logic [15:0] ptr_b;
		logic [15:0] base;
		logic [6:0]  short_off;
		logic [15:0] sp;
		logic [15:0] wdata;
	} access_req_t;

	// One program address request
	typedef struct packed {
		logic        valid;
		pmode_t      mode;
		logic [15:0] ptr;
		logic [15:0] acc;
		logic [15:0] pc;
		logic [6:0]  rel_off;
	} prog_req_t;

	// Memory command toward one port
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_cmd_t;

	// Read answer
	typedef struct packed {
		logic        valid;
		logic        dual;
		logic [15:0] data_a;
		logic [15:0] data_b;
	} rd_resp_t;
endpackage

// ---- dsp_data_space_access_unit.sv ----
// Purpose: Data space region split, write buffer, address forming.
// Assumes: Memories answer reads one cycle after the command.
// Notes: All outputs are registered; reads answer three cycles on.
module dsp_data_space_access_unit (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	input  wire logic [5:0]                    i_lower_boundary_config,
	input  wire logic [5:0]                    i_upper_boundary_config,
	input  wire dsp_data_space_pkg::access_req_t i_req,
	input  wire logic                          i_flow_change,
	input  wire logic                          i_st1_wr,
	input  wire logic [15:0]                   i_st1_wdata,
	input  wire logic                          i_page_load,
	input  wire logic [7:0]                    i_page_data,
	input  wire dsp_data_space_pkg::prog_req_t i_prog_req,
	input  wire logic [15:0]                   i_xy_rdata,
	input  wire logic [15:0]                   i_yb_rdata,
	input  wire logic [15:0]                   i_z_rdata,
	output dsp_data_space_pkg::mem_cmd_t       o_xy_cmd,
	output logic                               o_yb_rd,
	output logic [15:0]                        o_yb_addr,
	output dsp_data_space_pkg::mem_cmd_t       o_z_cmd,
	output dsp_data_space_pkg::rd_resp_t       o_rd,
	output logic                               o_busy,
	output logic                               o_region_fault,
	output logic                               o_buf_valid,
	output logic [15:0]                        o_status_reg_one,
	output logic                               o_prog_valid,
	output logic [15:0]                        o_prog_addr
);
	import dsp_data_space_pkg::*;

	// Sequencer states
	typedef enum logic [1:0] {
		S_IDLE = 2'h1,
		S_LONG = 2'h2
	} state_t;
	// Region of an address against the two boundary codes
	function automatic region_t region_of(
		input logic [15:0] addr,
		input logic [5:0]  lo,
		input logic [5:0]  hi
	);
		region_t r;
		r = R_MIDDLE;
		if (addr[15:REG_LSB] < lo) begin
			r = R_LOWER; // RL1 RL23
		end else if (addr[15:REG_LSB] >= hi) begin
			r = R_UPPER; // RL2 RL23
		end
		return r;
	endfunction
	// Sign extension of a seven-bit offset
	function automatic logic [15:0] sext7(input logic [6:0] v);
		return {{9{v[6]}}, v};
	endfunction
	// Boundary synchronisers and settled codes
	logic [5:0] lo_sync [SYNC_N]; // Lower code stages
	logic [5:0] hi_sync [SYNC_N]; // Upper code stages
	logic [5:0] lo_code;          // Settled lower code
	logic [5:0] hi_code;          // Settled upper code
	// Sequencer and held long request
	state_t      state;      // Current state
	state_t      next_state; // Following state
	access_req_t held;       // Long direct request waiting
	access_req_t cur;        // Request being served
	// Write buffer contents
	logic        buf_valid; // Entry loaded
	logic [15:0] buf_addr;  // Buffered address
	logic [15:0] buf_data;  // Buffered data
	// Read pipeline: stage one aligns with the command
	logic        p1_rd;   // Read in flight
	logic        p1_dual; // Dual read in flight
	logic        p1_z;    // Middle region read
	logic        p1_fa;   // Port A forwarded
	logic        p1_fb;   // Port B forwarded
	logic [15:0] p1_fwd;  // Forwarded data
	logic        p2_rd;   // Stage two copies
	logic        p2_dual;
	logic        p2_z;
	logic        p2_fa;
	logic        p2_fb;
	logic [15:0] p2_fwd;
	// Status register holding the page
	logic [15:0] st1; // Page in bits 7..0
	// Combinational decisions
	logic        take;     // New request accepted
	logic        fire;     // Request acts this cycle
	logic        fire_ok;  // Port A free of forced drain
	logic [15:0] addr_a;   // Formed address
	region_t     reg_a;    // Region of addr_a
	region_t     reg_b;    // Region of second pointer
	logic        fault;    // Mode cannot reach region
	logic        fwd_a;    // Port A hits the buffer
	logic        fwd_b;    // Port B hits the buffer
	logic        rd_a;     // Port A memory read
	logic        rd_b;     // Port B memory read
	logic        wr_new;   // Lower or upper write
	logic        z_acc;    // Middle region access
	logic        drain;    // Buffer writes memory
	logic        is_read;  // Any read served

	// Boundary pins are asynchronous to the core clock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < SYNC_N; i++) begin
				lo_sync[i] <= LOWER_RST;
				hi_sync[i] <= UPPER_RST;
			end
		end else begin
			lo_sync[0] <= i_lower_boundary_config; // RL6
			hi_sync[0] <= i_upper_boundary_config; // RL6
			for (int i = 1; i < SYNC_N; i++) begin
				lo_sync[i] <= lo_sync[i-1];
				hi_sync[i] <= hi_sync[i-1];
			end
		end
	end

	// A new code counts once stages two and three agree
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lo_code <= LOWER_RST;
			hi_code <= UPPER_RST;
		end else begin
			if (lo_sync[1] == lo_sync[2]) begin
				lo_code <= lo_sync[2]; // RL4
			end
			if (hi_sync[1] == hi_sync[2]) begin
				hi_code <= hi_sync[2]; // RL4
			end
		end
	end

	// Page register and its view; a register write beats a page load
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st1              <= ST1_RST;
			o_status_reg_one <= ST1_RST;
		end else begin
			o_status_reg_one <= st1;
			if (i_st1_wr) begin
				st1 <= i_st1_wdata & ST1_WR_MASK; // RL22
			end else if (i_page_load) begin
				st1[PAGE_W-1:0] <= i_page_data; // RL22
			end
		end
	end

	// Request selection and address forming
	always_comb begin
		take    = 1'b0;
		fire_ok = !(i_flow_change && buf_valid);
		cur     = held;
		fire    = 1'b0;
		case (state)
			S_IDLE: begin
				// No request is taken while the flow changes
				take = i_req.valid && !i_flow_change;
				cur  = i_req;
				fire = take && (i_req.mode != M_LONG_DIRECT);
			end
			S_LONG: begin
				fire = fire_ok; // RL15
			end
			default: begin
				fire = 1'b0;
			end
		endcase
		case (cur.mode)
			M_SHORT_DIRECT: addr_a = {st1[PAGE_W-1:0], cur.short_addr}; // RL14
			M_LONG_DIRECT:  addr_a = cur.long_word; // RL15
			M_INDIRECT:     addr_a = cur.ptr_a; // RL16
			M_DUAL:         addr_a = cur.ptr_a; // RL16
			M_SHORT_INDEX:  addr_a = cur.base + sext7(cur.short_off); // RL17
			M_LONG_INDEX:   addr_a = cur.base + cur.long_word; // RL18
			M_STACK:        addr_a = cur.sp; // RL19
			default:        addr_a = cur.long_word;
		endcase
	end

	// Region checks and buffer decisions
	always_comb begin
		reg_a = region_of(addr_a, lo_code, hi_code); // RL3
		reg_b = region_of(cur.ptr_b, lo_code, hi_code);
		fault = 1'b0;
		// Pointer and long index modes cannot reach the middle
		if ((cur.mode == M_INDIRECT || cur.mode == M_LONG_INDEX) &&
		    reg_a == R_MIDDLE) begin
			fault = 1'b1; // RL16 RL18
		end
		// Dual reads need one lower and one upper word
		if (cur.mode == M_DUAL &&
		    (reg_a != R_LOWER || reg_b != R_UPPER || cur.write)) begin
			fault = 1'b1; // RL16
		end
		fault   = fault && fire;
		is_read = fire && !fault && !cur.write;
		fwd_a   = buf_valid && (buf_addr == addr_a); // RL12
		fwd_b   = buf_valid && (buf_addr == cur.ptr_b); // RL12
		z_acc   = fire && !fault && (reg_a == R_MIDDLE); // RL13
		rd_a    = is_read && (reg_a != R_MIDDLE) && !fwd_a;
		rd_b    = is_read && (cur.mode == M_DUAL) && !fwd_b;
		wr_new  = fire && !fault && cur.write && (reg_a != R_MIDDLE); // RL7
		// Port A memory reads and middle accesses hold the buffer back; forwarded reads let it drain
		drain = buf_valid && (wr_new || (!rd_a && !z_acc)); // RL8 RL9 RL10
	end

	// Sequencer for the two-cycle long direct access
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (take && i_req.mode == M_LONG_DIRECT) begin
					next_state = S_LONG; // RL15
				end
			end
			S_LONG: begin
				if (fire_ok) begin
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// State, held request and busy flag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state  <= S_IDLE;
			held   <= '0;
			o_busy <= 1'b0;
		end else begin
			state  <= next_state;
			// Busy marks the cycles a held request blocks new ones
			o_busy <= (next_state == S_LONG);
			if (take) begin
				held <= i_req;
			end
		end
	end

	// One-entry write buffer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			buf_valid <= 1'b0;
			buf_addr  <= '0;
			buf_data  <= '0;
		end else if (wr_new) begin
			buf_valid <= 1'b1; // RL7 RL10
			buf_addr  <= addr_a;
			buf_data  <= cur.wdata;
		end else if (drain) begin
			// Flow changes always drain, since nothing fires then
			buf_valid <= 1'b0; // RL9 RL11
		end
	end

	// Lower and upper ports: A reads and drains, B reads for dual operands
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_xy_cmd  <= '0;
			o_yb_rd   <= 1'b0;
			o_yb_addr <= '0;
		end else begin
			o_xy_cmd.rd    <= rd_a; // RL8
			o_xy_cmd.wr    <= drain; // RL9
			o_xy_cmd.addr  <= drain ? buf_addr : addr_a;
			o_xy_cmd.wdata <= buf_data;
			o_yb_rd        <= rd_b; // RL16
			o_yb_addr      <= cur.ptr_b;
		end
	end

	// Middle region port, never buffered
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_z_cmd <= '0;
		end else begin
			o_z_cmd.rd    <= z_acc && !cur.write; // RL13
			o_z_cmd.wr    <= z_acc && cur.write; // RL13
			o_z_cmd.addr  <= addr_a;
			o_z_cmd.wdata <= cur.wdata;
		end
	end

	// Fault and buffer state flags
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_region_fault <= 1'b0;
			o_buf_valid    <= 1'b0;
		end else begin
			o_region_fault <= fault;
			o_buf_valid    <= wr_new || (buf_valid && !drain);
		end
	end

	// Read pipeline keeps forwarded reads at memory latency
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			p1_rd   <= 1'b0;
			p1_dual <= 1'b0;
			p1_z    <= 1'b0;
			p1_fa   <= 1'b0;
			p1_fb   <= 1'b0;
			p1_fwd  <= '0;
			p2_rd   <= 1'b0;
			p2_dual <= 1'b0;
			p2_z    <= 1'b0;
			p2_fa   <= 1'b0;
			p2_fb   <= 1'b0;
			p2_fwd  <= '0;
		end else begin
			p1_rd   <= is_read;
			p1_dual <= is_read && (cur.mode == M_DUAL);
			p1_z    <= reg_a == R_MIDDLE;
			p1_fa   <= fwd_a && (reg_a != R_MIDDLE); // RL12
			p1_fb   <= fwd_b;
			p1_fwd  <= buf_data;
			p2_rd   <= p1_rd;
			p2_dual <= p1_dual;
			p2_z    <= p1_z;
			p2_fa   <= p1_fa;
			p2_fb   <= p1_fb;
			p2_fwd  <= p1_fwd;
		end
	end

	// Read answer from memory, middle port or buffer copy
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rd <= '0;
		end else begin
			o_rd.valid <= p2_rd;
			o_rd.dual  <= p2_dual;
			if (p2_z) begin
				o_rd.data_a <= i_z_rdata;
			end else if (p2_fa) begin
				o_rd.data_a <= p2_fwd; // RL12
			end else begin
				o_rd.data_a <= i_xy_rdata;
			end
			o_rd.data_b <= p2_fb ? p2_fwd : i_yb_rdata;
		end
	end

	// Program memory address forming
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_prog_valid <= 1'b0;
			o_prog_addr  <= '0;
		end else begin
			o_prog_valid <= i_prog_req.valid;
			case (i_prog_req.mode)
				P_POINTER: o_prog_addr <= i_prog_req.ptr; // RL20
				P_ACCUM:   o_prog_addr <= i_prog_req.acc; // RL20
				// Offset -64..+63 plus one gives pc-63..pc+64
				P_REL: o_prog_addr <= i_prog_req.pc + REL_BIAS +
					sext7(i_prog_req.rel_off); // RL21
				default: o_prog_addr <= i_prog_req.pc;
			endcase
		end
	end
endmodule

// ---- dsp_data_space_access_unit_assertions.sv ----
// Purpose: Port checks for the data space access unit.
// Assumes: Synchronous active-high reset, one clock.
// Notes: Region choice is judged by the bench, not here.
module dsp_data_space_access_unit_assertions (
	input wire logic                            i_clk,
	input wire logic                            i_rst,
	input wire dsp_data_space_pkg::access_req_t i_req,
	input wire logic                            i_flow_change,
	input wire logic                            i_st1_wr,
	input wire logic [15:0]                     i_st1_wdata,
	input wire logic                            i_page_load,
	input wire logic [7:0]                      i_page_data,
	input wire dsp_data_space_pkg::prog_req_t   i_prog_req,
	input wire dsp_data_space_pkg::mem_cmd_t    o_xy_cmd,
	input wire logic                            o_yb_rd,
	input wire dsp_data_space_pkg::mem_cmd_t    o_z_cmd,
	input wire dsp_data_space_pkg::rd_resp_t    o_rd,
	input wire logic                            o_busy,
	input wire logic                            o_region_fault,
	input wire logic                            o_buf_valid,
	input wire logic [15:0]                     o_status_reg_one,
	input wire logic                            o_prog_valid,
	input wire logic [15:0]                     o_prog_addr
);
	import dsp_data_space_pkg::*;
	logic [15:0] rel_tgt; // Relative target one cycle on

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Expected branch target, kept apart so the property stays short
	always_ff @(posedge i_clk) begin
		rel_tgt <= i_prog_req.pc + 16'h0001 + {{9{i_prog_req.rel_off[6]}}, i_prog_req.rel_off};
	end

	a_drain_idle: assert property (o_buf_valid && !i_req.valid && !o_busy |=> o_xy_cmd.wr)
		else $error("loaded buffer idle without drain");
	a_flow_drain: assert property (i_flow_change && o_buf_valid |=> o_xy_cmd.wr && !o_buf_valid)
		else $error("flow change left buffer loaded");
	a_read_first: assert property (o_xy_cmd.rd |-> !o_xy_cmd.wr)
		else $error("write issued beside a read");
	a_read_answer: assert property (o_xy_cmd.rd || o_z_cmd.rd |-> ##2 o_rd.valid)
		else $error("read answer missing");
	a_dual_pair: assert property (o_yb_rd |-> (o_xy_cmd.rd || o_xy_cmd.wr)
		##2 o_rd.valid && o_rd.dual)
		else $error("dual read not paired");
	a_middle_bypass: assert property (o_z_cmd.rd || o_z_cmd.wr |-> $stable(o_buf_valid))
		else $error("middle access touched buffer");
	a_busy_once: assert property (o_busy && !i_flow_change && !o_buf_valid |=> !o_busy)
		else $error("long direct held too long");
	a_fault_quiet: assert property (o_region_fault |-> !(o_xy_cmd.rd || o_z_cmd.rd || o_z_cmd.wr))
		else $error("faulted request made an access");
	a_prog_pointer: assert property (i_prog_req.valid && i_prog_req.mode == P_POINTER
		|=> o_prog_valid && o_prog_addr == $past(i_prog_req.ptr))
		else $error("pointer program address wrong");
	a_prog_accum: assert property (i_prog_req.valid && i_prog_req.mode == P_ACCUM
		|=> o_prog_valid && o_prog_addr == $past(i_prog_req.acc))
		else $error("accumulator program address wrong");
	a_prog_rel: assert property (i_prog_req.valid && i_prog_req.mode == P_REL
		|=> o_prog_addr == rel_tgt)
		else $error("relative target wrong");
	a_page_load: assert property (i_page_load && !i_st1_wr ##1 !i_st1_wr && !i_page_load
		|=> o_status_reg_one[7:0] == $past(i_page_data, 2))
		else $error("page field not loaded");
	a_status_mask: assert property (i_st1_wr ##1 !i_st1_wr && !i_page_load
		|=> o_status_reg_one == ($past(i_st1_wdata, 2) & ST1_WR_MASK))
		else $error("status write not masked");
endmodule

// ---- dsp_data_mem_model.sv ----
// Purpose: Data memory array behind the access unit.
// Assumes: One shared array serves all three ports.
// Notes: Read data stands one cycle, then shows its inverse.
module dsp_data_mem_model (
	input  wire logic                         i_clk,
	input  wire dsp_data_space_pkg::mem_cmd_t i_xy_cmd,
	input  wire logic                         i_yb_rd,
	input  wire logic [15:0]                  i_yb_addr,
	input  wire dsp_data_space_pkg::mem_cmd_t i_z_cmd,
	output logic [15:0]                       o_xy_rdata,
	output logic [15:0]                       o_yb_rdata,
	output logic [15:0]                       o_z_rdata
);
	import dsp_data_space_pkg::*;
	logic [15:0] mem [65536]; // Whole data space

	// Answer one cycle after the command; invert otherwise so data an odd number of cycles stale never passes
	always @(posedge i_clk) begin
		o_xy_rdata <= i_xy_cmd.rd ? mem[i_xy_cmd.addr] : ~o_xy_rdata;
		o_yb_rdata <= i_yb_rd ? mem[i_yb_addr] : ~o_yb_rdata;
		o_z_rdata <= i_z_cmd.rd ? mem[i_z_cmd.addr] : ~o_z_rdata;
		if (i_xy_cmd.wr) mem[i_xy_cmd.addr] <= i_xy_cmd.wdata;
		if (i_z_cmd.wr) mem[i_z_cmd.addr] <= i_z_cmd.wdata;
	end
endmodule

// ---- tb_dsp_data_space_access_unit.sv ----
// Purpose: Self-checking bench for the data space access unit.
// Assumes: Boundary pins settle within five cycles.
// Notes: Inputs change 1 ns after the rising edge.
module tb_dsp_data_space_access_unit;
	timeunit 1ns;
	timeprecision 100ps;
	import dsp_data_space_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [5:0]  i_lower_boundary_config = 6'h04; // Lower region 4K
	logic [5:0]  i_upper_boundary_config = 6'h3c; // Upper from 0xf000
	access_req_t i_req = '0;
	logic        i_flow_change = 1'b0;
	logic        i_st1_wr = 1'b0;
	logic [15:0] i_st1_wdata = '0;
	logic        i_page_load = 1'b0;
	logic [7:0]  i_page_data = '0;
	prog_req_t   i_prog_req = '0;
	logic [15:0] i_xy_rdata, i_yb_rdata, i_z_rdata;
	mem_cmd_t    o_xy_cmd, o_z_cmd;
	rd_resp_t    o_rd;
	logic        o_yb_rd, o_busy, o_region_fault, o_buf_valid, o_prog_valid;
	logic [15:0] o_yb_addr, o_status_reg_one, o_prog_addr;
	int          error_cnt = 0;
	int          compares = 0;

	always #2.5 i_clk = ~i_clk;

	dsp_data_space_access_unit dsp_data_space_access_unit_i (.i_clk, .i_rst,
		.i_lower_boundary_config, .i_upper_boundary_config, .i_req, .i_flow_change,
		.i_st1_wr, .i_st1_wdata, .i_page_load, .i_page_data, .i_prog_req, .i_xy_rdata,
		.i_yb_rdata, .i_z_rdata, .o_xy_cmd, .o_yb_rd, .o_yb_addr, .o_z_cmd, .o_rd,
		.o_busy, .o_region_fault, .o_buf_valid, .o_status_reg_one, .o_prog_valid,
		.o_prog_addr);

	dsp_data_mem_model dsp_data_mem_model_i (.i_clk, .i_xy_cmd(o_xy_cmd),
		.i_yb_rd(o_yb_rd), .i_yb_addr(o_yb_addr), .i_z_cmd(o_z_cmd),
		.o_xy_rdata(i_xy_rdata), .o_yb_rdata(i_yb_rdata), .o_z_rdata(i_z_rdata));

	// Idle cycle: requests drop here, never in the step a new one starts
	task automatic tick();
		i_req = '0;
		i_prog_req = '0;
		@(posedge i_clk);
		#1;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkb(input string n, input logic e, input logic g);
		chk(n, {15'h0000, e}, {15'h0000, g});
	endtask

	function automatic access_req_t mk(dmode_t m, logic w, logic [15:0] a, logic [15:0] d);
		mk = '{valid: 1'b1, write: w, mode: m, short_addr: a[7:0], long_word: a,
			ptr_a: a, ptr_b: a, base: a, short_off: 7'h00, sp: a, wdata: d};
	endfunction

	// One request cycle; it stands until the next call or tick replaces it
	task automatic go(input access_req_t r);
		i_req = r;
		@(posedge i_clk);
		#1;
	endtask

	task automatic await_read(input logic [15:0] e);
		tick();
		tick();
		chkb("rd_valid", 1'b1, o_rd.valid);
		chk("rd_data", e, o_rd.data_a);
	endtask

	task automatic probe(input access_req_t r, input logic [15:0] e);
		go(r);
		chkb("rd_cmd", 1'b1, o_xy_cmd.rd);
		chk("rd_addr", e, o_xy_cmd.addr);
	endtask

	task automatic t_buffer();
		go(mk(M_INDIRECT, 1'b1, 16'h0010, 16'h1234));
		chkb("buf_valid", 1'b1, o_buf_valid);
		chkb("early_wr", 1'b0, o_xy_cmd.wr);
		tick();
		chkb("drain_wr", 1'b1, o_xy_cmd.wr);
		chk("drain_addr", 16'h0010, o_xy_cmd.addr);
		chk("drain_data", 16'h1234, o_xy_cmd.wdata);
		go(mk(M_INDIRECT, 1'b1, 16'hf010, 16'h6789));
		tick();
	endtask

	// Read beats a waiting write, then a read of the buffered word forwards
	task automatic t_order();
		go(mk(M_INDIRECT, 1'b1, 16'h0020, 16'hbeef));
		go(mk(M_INDIRECT, 1'b0, 16'h0010, '0));
		chkb("prio_rd", 1'b1, o_xy_cmd.rd);
		go(mk(M_INDIRECT, 1'b0, 16'h0020, '0));
		tick();
		chk("prio_data", 16'h1234, o_rd.data_a);
		tick();
		chk("fwd_data", 16'hbeef, o_rd.data_a);
		go(mk(M_INDIRECT, 1'b1, 16'h0040, 16'h1111));
		go(mk(M_INDIRECT, 1'b1, 16'h0041, 16'h2222));
		chk("flush_addr", 16'h0040, o_xy_cmd.addr);
		chkb("reload", 1'b1, o_buf_valid);
		tick();
		chk("reload_addr", 16'h0041, o_xy_cmd.addr);
	endtask

	task automatic t_flow();
		go(mk(M_INDIRECT, 1'b1, 16'h0050, 16'h3333));
		i_flow_change = 1'b1;
		go(mk(M_INDIRECT, 1'b0, 16'h0010, '0));
		i_flow_change = 1'b0;
		chkb("flow_wr", 1'b1, o_xy_cmd.wr);
		chkb("flow_refused", 1'b0, o_xy_cmd.rd);
		chkb("flow_empty", 1'b0, o_buf_valid);
	endtask

	task automatic t_middle();
		go(mk(M_SHORT_INDEX, 1'b1, 16'h2000, 16'h5555));
		chkb("z_wr", 1'b1, o_z_cmd.wr);
		chk("z_addr", 16'h2000, o_z_cmd.addr);
		chk("z_data", 16'h5555, o_z_cmd.wdata);
		chkb("z_unbuffered", 1'b0, o_buf_valid);
		go(mk(M_SHORT_INDEX, 1'b0, 16'h2000, '0));
		chkb("z_rd", 1'b1, o_z_cmd.rd);
		await_read(16'h5555);
	endtask

	task automatic t_modes();
		access_req_t r;
		i_st1_wr = 1'b1;
		i_st1_wdata = 16'hff00;
		tick();
		i_st1_wr = 1'b0;
		tick();
		chk("st1", 16'hfc00, o_status_reg_one);
		i_page_load = 1'b1;
		i_page_data = 8'hff;
		tick();
		i_page_load = 1'b0;
		probe(mk(M_SHORT_DIRECT, 1'b0, 16'h0080, '0), 16'hff80);
		chk("page", 16'hfcff, o_status_reg_one);
		r = mk(M_LONG_DIRECT, 1'b0, 16'h0300, '0);
		r.long_word = 16'h0100;
		go(r);
		chkb("ld_busy", 1'b1, o_busy);
		chkb("ld_early", 1'b0, o_xy_cmd.rd);
		tick();
		chk("ld_addr", 16'h0100, o_xy_cmd.addr);
		r = mk(M_SHORT_INDEX, 1'b0, 16'h0100, '0);
		r.short_off = 7'h40;
		probe(r, 16'h00c0);
		r.short_off = 7'h3f;
		probe(r, 16'h013f);
		r = mk(M_LONG_INDEX, 1'b0, 16'h0100, '0);
		r.long_word = 16'hff00;
		probe(r, 16'h0000);
		r = mk(M_STACK, 1'b0, 16'h0300, '0);
		r.sp = 16'h0200;
		probe(r, 16'h0200);
		r = mk(M_DUAL, 1'b0, 16'h0010, '0);
		r.ptr_b = 16'hf010;
		probe(r, 16'h0010);
		chk("yb_addr", 16'hf010, o_yb_addr);
		chkb("yb_rd", 1'b1, o_yb_rd);
		tick();
		tick();
		chk("dual_b", 16'h6789, o_rd.data_b);
		chk("dual_a", 16'h1234, o_rd.data_a);
		chkb("dual", 1'b1, o_rd.dual);
		go(mk(M_INDIRECT, 1'b0, 16'h2000, '0));
		chkb("fault", 1'b1, o_region_fault);
		tick();
		chkb("fault_pulse", 1'b0, o_region_fault);
	endtask

	task automatic pg(input pmode_t m, input logic [6:0] off, input logic [15:0] e);
		i_prog_req = '{1'b1, m, 16'h1111, 16'h2222, 16'h0100, off};
		@(posedge i_clk);
		#1;
		chkb("prog_valid", 1'b1, o_prog_valid);
		chk("prog_addr", e, o_prog_addr);
	endtask

	task automatic t_region(input logic [15:0] a, input logic mid);
		go(mk(M_SHORT_INDEX, 1'b0, a, '0));
		chkb("mid_rd", mid, o_z_cmd.rd);
		chkb("side_rd", !mid, o_xy_cmd.rd);
	endtask

	task automatic give_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge i_clk);
		#1 i_rst = 1'b0;
		repeat (5) tick();
		t_buffer();
		t_order();
		t_flow();
		t_middle();
		t_modes();
		pg(P_POINTER, 7'h00, 16'h1111);
		pg(P_ACCUM, 7'h00, 16'h2222);
		pg(P_REL, 7'h40, 16'h00c1);
		pg(P_REL, 7'h3f, 16'h0140);
		t_region(16'h0fff, 1'b0);
		t_region(16'h1000, 1'b1);
		t_region(16'hefff, 1'b1);
		t_region(16'hf000, 1'b0);
		i_lower_boundary_config = 6'h00;
		i_upper_boundary_config = 6'h3f;
		repeat (5) tick();
		t_region(16'h0000, 1'b1);
		t_region(16'hfbff, 1'b1);
		t_region(16'hfc00, 1'b0);
		give_verdict();
	end
endmodule

bind dsp_data_space_access_unit dsp_data_space_access_unit_assertions assertions_i (
	.i_clk, .i_rst, .i_req, .i_flow_change, .i_st1_wr, .i_st1_wdata, .i_page_load,
	.i_page_data, .i_prog_req, .o_xy_cmd, .o_yb_rd, .o_z_cmd, .o_rd, .o_busy,
	.o_region_fault, .o_buf_valid, .o_status_reg_one, .o_prog_valid, .o_prog_addr);
